// ===== dpdt_map.vh
// Register map, field positions and reset values of the dual timer.
`ifndef DPDT_MAP_VH
`define DPDT_MAP_VH

`define DPDT_T1_PSC_ADDR   8'hd2
`define DPDT_T1_CNT_ADDR   8'hd3
`define DPDT_T1_CSR_ADDR   8'hd4
`define DPDT_T2_PSC_ADDR   8'hd5
`define DPDT_T2_CNT_ADDR   8'hd6
`define DPDT_T2_CSR_ADDR   8'hd7

`define DPDT_CSR_ZERO_BIT  7
`define DPDT_CSR_IEN_BIT   6
`define DPDT_CSR_RUN_BIT   3
`define DPDT_CSR_TAP_MSB   2
`define DPDT_CSR_TAP_LSB   0
`define DPDT_CSR_WMASK     8'hcf

`define DPDT_CNT_RESET     8'hff
`define DPDT_PSC_RESET     7'h7f
`define DPDT_CSR_RESET     8'h00

`define DPDT_FDIV          12
`define DPDT_FDIV_W        4

`endif

// ===== dpdt_timer.v
// One 8-bit down counter with its 7-bit prescaler and control register.
`timescale 1ns/10ps
`default_nettype none
`include "dpdt_map.vh"

module dpdt_timer (
    input  wire       mclk,
    input  wire       rstN,
    input  wire       tick,
    input  wire       pscWr,
    input  wire       cntWr,
    input  wire       csrWr,
    input  wire [7:0] wrData,
    output reg  [6:0] pscVal_q,
    output reg  [7:0] cntVal_q,
    output wire [7:0] csrVal,
    output reg        irq_q
);

    reg        zero_q;
    reg        ien_q;
    reg        run_q;
    reg  [2:0] tap_q;
    reg  [6:0] pscVal_d;
    reg  [7:0] cntVal_d;
    reg        zero_d;
    reg  [6:0] pscOld_q;
    wire [6:0] pscRise;
    wire [7:0] edgeVec;
    wire       cntEdge;

    assign csrVal = {zero_q, ien_q, 2'b00, run_q, tap_q};

    // Tap 0 is the prescaler input itself; higher taps follow prescaler bits.
    // Rising edges are found on every prescaler bit at once, so a change of
    // tap or a restart from the all-ones state never fakes a counter clock.
    assign pscRise = pscVal_q & ~pscOld_q;
    assign edgeVec = {pscRise, tick};
    assign cntEdge = run_q & edgeVec[tap_q];

    always @* begin
        pscVal_d = pscVal_q;
        if (!run_q)
            pscVal_d = `DPDT_PSC_RESET;
        else if (pscWr)
            pscVal_d = wrData[6:0];
        else if (tick)
            pscVal_d = pscVal_q - 7'h01;
    end

    always @* begin
        cntVal_d = cntVal_q;
        zero_d   = zero_q;
        if (csrWr)
            zero_d = wrData[`DPDT_CSR_ZERO_BIT];
        if (cntWr) begin
            cntVal_d = wrData;
            if (wrData == 8'h00)
                zero_d = 1'b1;
        end else if (cntEdge) begin
            cntVal_d = cntVal_q - 8'h01;
            if (cntVal_q == 8'h01)
                zero_d = 1'b1;
        end
    end

    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            pscVal_q <= `DPDT_PSC_RESET;
            cntVal_q <= `DPDT_CNT_RESET;
            zero_q   <= 1'b0;
            ien_q    <= 1'b0;
            run_q    <= 1'b0;
            tap_q    <= 3'b000;
            pscOld_q <= `DPDT_PSC_RESET;
            irq_q    <= 1'b0;
        end else begin
            pscVal_q <= pscVal_d;
            cntVal_q <= cntVal_d;
            zero_q   <= zero_d;
            pscOld_q <= pscVal_q;
            if (csrWr) begin
                ien_q <= wrData[`DPDT_CSR_IEN_BIT];
                run_q <= wrData[`DPDT_CSR_RUN_BIT];
                tap_q <= wrData[`DPDT_CSR_TAP_MSB:`DPDT_CSR_TAP_LSB];
            end
            irq_q <= zero_q & ien_q;
        end
    end

endmodule // dpdt_timer

`default_nettype wire

// ===== dpdt_top.v
// Two prescaled down timers behind the core's data-space register port.
//
// Functional notes
// - Two independent timers, each complete.
// - Counter decrements on selected tap rising edge.
// - Software loads and reads counter anytime.
// - Decrement to zero sets zero flag.
// - Request while flag and enable both set.
// - Request line also wakes core from wait.
// - Prescaler counts down at clock divided twelve.
// - Tap zero is prescaler input, others bits.
// - Tap field value is power-of-two exponent.
// - Run bit low forces prescaler 7Fh, stops.
// - Run bit high counts, prescaler loadable.
// - Writing 00h or flag bit sets flag.
// - Reset: counter FFh, prescaler 7Fh, control cleared.
// - Counter write beats simultaneous zero decrement.
// - Counter and prescaler read back exactly; prescaler reads 7Fh while run bit low.
// - Control layout: flag7, enable6, run3, tap2-0.
// - First counter register at D3h.
// - First prescaler at D2h, bit7 reads zero.
// - Second control register at D7h.
`timescale 1ns/10ps
`default_nettype none
`include "dpdt_map.vh"

module dpdt_top (
    input  wire       mclk,
    input  wire       nrst,
    input  wire [7:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrEn,
    input  wire       regRdEn,
    output reg  [7:0] regRdData_q,
    output reg        timer1Irq_q,
    output reg        timer2Irq_q
);

    ////////////////////////////////////////////////////////////////////////
    reg                    rstSync1_q;
    reg                    rstSync2_q;
    reg [`DPDT_FDIV_W-1:0] divCnt_q;
    reg                    tick_q;
    wire [6:0]             psc1;
    wire [6:0]             psc2;
    wire [7:0]             cnt1;
    wire [7:0]             cnt2;
    wire [7:0]             csr1;
    wire [7:0]             csr2;
    wire                   irq1;
    wire                   irq2;
    reg  [7:0]             rdData_d;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One shared divide-by-twelve strobe feeds both prescalers.
    always @(posedge mclk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            divCnt_q <= {`DPDT_FDIV_W{1'b0}};
            tick_q   <= 1'b0;
        end else begin
            tick_q <= (divCnt_q == `DPDT_FDIV - 1);
            if (divCnt_q == `DPDT_FDIV - 1)
                divCnt_q <= {`DPDT_FDIV_W{1'b0}};
            else
                divCnt_q <= divCnt_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    dpdt_timer uTimer1 (
        .mclk     (mclk),
        .rstN     (rstSync2_q),
        .tick     (tick_q),
        .pscWr    (regWrEn && regAddr == `DPDT_T1_PSC_ADDR),
        .cntWr    (regWrEn && regAddr == `DPDT_T1_CNT_ADDR),
        .csrWr    (regWrEn && regAddr == `DPDT_T1_CSR_ADDR),
        .wrData   (regWrData),
        .pscVal_q (psc1),
        .cntVal_q (cnt1),
        .csrVal   (csr1),
        .irq_q    (irq1)
    );

    dpdt_timer uTimer2 (
        .mclk     (mclk),
        .rstN     (rstSync2_q),
        .tick     (tick_q),
        .pscWr    (regWrEn && regAddr == `DPDT_T2_PSC_ADDR),
        .cntWr    (regWrEn && regAddr == `DPDT_T2_CNT_ADDR),
        .csrWr    (regWrEn && regAddr == `DPDT_T2_CSR_ADDR),
        .wrData   (regWrData),
        .pscVal_q (psc2),
        .cntVal_q (cnt2),
        .csrVal   (csr2),
        .irq_q    (irq2)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reads sample live values; unmapped addresses return zero.
    always @* begin
        case (regAddr)
            `DPDT_T1_PSC_ADDR: rdData_d = {1'b0, psc1};
            `DPDT_T1_CNT_ADDR: rdData_d = cnt1;
            `DPDT_T1_CSR_ADDR: rdData_d = csr1;
            `DPDT_T2_PSC_ADDR: rdData_d = {1'b0, psc2};
            `DPDT_T2_CNT_ADDR: rdData_d = cnt2;
            `DPDT_T2_CSR_ADDR: rdData_d = csr2;
            default:           rdData_d = 8'h00;
        endcase
    end

    always @(posedge mclk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            regRdData_q <= 8'h00;
            timer1Irq_q <= 1'b0;
            timer2Irq_q <= 1'b0;
        end else begin
            if (regRdEn)
                regRdData_q <= rdData_d;
            timer1Irq_q <= irq1;
            timer2Irq_q <= irq2;
        end
    end

endmodule // dpdt_top

`default_nettype wire

// ===== dpdt_monitor.sv
// Port-level assertions for the dual prescaled down timer.
`timescale 1ns/10ps
`default_nettype none
module dpdt_monitor (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData_q,
    input wire logic       timer1Irq_q,
    input wire logic       timer2Irq_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic mapped = regAddr >= 8'hd2 && regAddr <= 8'hd7;
    wire logic w1 = regWrEn && regAddr == 8'hd4;
    wire logic w2 = regWrEn && regAddr == 8'hd7;
    a_unmapped_read_zero: assert property (regRdEn && !mapped
        |=> regRdData_q == 8'h00) else $error("unmapped read not zero");
    a_psc_top_zero: assert property (regRdEn && (regAddr == 8'hd2 ||
        regAddr == 8'hd5) |=> !regRdData_q[7]) else $error("psc bit7 set");
    a_csr_gap_zero: assert property (regRdEn && (regAddr == 8'hd4 ||
        regAddr == 8'hd7) |=> regRdData_q[5:4] == 2'b00)
        else $error("csr bits 5:4 set");
    a_rdata_held: assert property (!regRdEn |=> $stable(regRdData_q))
        else $error("read data moved without read");
    a_t1_irq_raise: assert property (w1 && regWrData[7:6] == 2'b11
        |-> ##3 timer1Irq_q) else $error("timer1 irq missing");
    a_t1_irq_masked: assert property (w1 && !regWrData[6]
        |-> ##3 !timer1Irq_q) else $error("timer1 irq not masked");
    a_t2_irq_raise: assert property (w2 && regWrData[7:6] == 2'b11
        |-> ##3 timer2Irq_q) else $error("timer2 irq missing");
    a_t2_irq_masked: assert property (w2 && !regWrData[6]
        |-> ##3 !timer2Irq_q) else $error("timer2 irq not masked");
    a_reset_quiet: assert property ($rose(nrst) |-> !timer1Irq_q &&
        !timer2Irq_q && regRdData_q == 8'h00) else $error("reset not quiet");
    c_t1_irq: cover property (w1 && regWrData[7:6] == 2'b11);
    c_t2_irq: cover property ($rose(timer2Irq_q));
    c_unmapped: cover property (regRdEn && !mapped);
endmodule // dpdt_monitor
bind dpdt_top dpdt_monitor i_dpdt_monitor (.mclk(mclk), .nrst(nrst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData_q(regRdData_q),
    .timer1Irq_q(timer1Irq_q), .timer2Irq_q(timer2Irq_q));
`default_nettype wire

// ===== tb_dpdt_top.sv
// Self-checking random testbench for the dual prescaled down timer.
`timescale 1ns/10ps
`default_nettype none
module tb_dpdt_top;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [7:0]  regWrData = 8'h00;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    wire  [7:0]  regRdData_q;
    wire         timer1Irq_q;
    wire         timer2Irq_q;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n;
    logic [31:0] rnd = 32'habc53927;
    logic [7:0]  v;
    logic [7:0]  a;
    logic        inSpan;
    always #2 mclk = ~mclk;
    dpdt_top i_dpdt_top (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData_q(regRdData_q), .timer1Irq_q(timer1Irq_q),
        .timer2Irq_q(timer2Irq_q));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge mclk);
        regAddr = ad;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge mclk);
        regWrEn = 1'b0;
    endtask
    // Read data is taken one and a half cycles after the read edge, so the
    // registered answer has surely landed.
    task automatic chk(input logic [7:0] ad, input logic [7:0] e);
        @(negedge mclk);
        regAddr = ad;
        regRdEn = 1'b1;
        @(negedge mclk);
        regRdEn = 1'b0;
        @(negedge mclk);
        cmp($sformatf("reg %h", ad), e, regRdData_q);
    endtask
    task automatic wirq(input logic sel, output int c);
        c = 0;
        while ((sel ? timer2Irq_q : timer1Irq_q) !== 1'b1) begin
            @(negedge mclk);
            c++;
            if (c > 4000) begin
                n_errors++;
                give_verdict();
            end
        end
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        repeat (3) @(negedge mclk);
        for (int i = 0; i < 6; i++) begin
            v = i % 3 == 0 ? 8'h7f : i % 3 == 1 ? 8'hff : 8'h00;
            chk(8'hd2 + i[7:0], v);
        end
        wr(8'hd9, 8'h55);
        chk(8'hd9, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            a = i[0] ? 8'hd6 : 8'hd3;
            wr(a, rnd[7:0] | 8'h01);
            chk(a, rnd[7:0] | 8'h01);
            wr(a - 8'h01, rnd[15:8]);
            chk(a - 8'h01, 8'h7f);
        end
        wr(8'hd3, 8'h00);
        chk(8'hd4, 8'h80);
        cmp("irq1 masked", 8'h00, {7'h0, timer1Irq_q});
        wr(8'hd4, 8'h40);
        chk(8'hd4, 8'h40);
        wr(8'hd4, 8'hf0);
        chk(8'hd4, 8'hc0);
        cmp("irq1 raised", 8'h01, {7'h0, timer1Irq_q});
        wr(8'hd4, 8'h00);
        wr(8'hd3, 8'h02);
        wr(8'hd4, 8'h48);
        wirq(1'b0, n);
        inSpan = n >= 12 && n <= 40;
        cmp("t1 span", 8'h01, {7'h0, inSpan});
        // The request showed two edges after a tick, so the next tick edge
        // is the one right after the strobe set nine falling edges from here.
        wr(8'hd4, 8'h48);
        wr(8'hd3, 8'h01);
        repeat (4) @(negedge mclk);
        wr(8'hd3, 8'h5a);
        rnd = xs(rnd);
        wr(8'hd2, rnd[7:0]);
        chk(8'hd2, {1'b0, rnd[6:0]});
        chk(8'hd4, 8'h48);
        chk(8'hd3, 8'h5a);
        cmp("irq1 cleared", 8'h00, {7'h0, timer1Irq_q});
        wr(8'hd4, 8'h00);
        wr(8'hd3, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(8'hd7, 8'h00);
            wr(8'hd6, 8'h02);
            wr(8'hd7, 8'h48 | k[7:0]);
            wirq(1'b1, n);
            inSpan = n >= (24 << k) - 12 && n <= (24 << k) + 16;
            cmp("t2 span", 8'h01, {7'h0, inSpan});
            chk(8'hd6, 8'h00);
        end
        wr(8'hd7, 8'h00);
        wr(8'hd7, 8'hc0);
        chk(8'hd7, 8'hc0);
        cmp("irq2 raised", 8'h01, {7'h0, timer2Irq_q});
        chk(8'hd3, 8'h00);
        give_verdict();
    end
endmodule // tb_dpdt_top
`default_nettype wire
